// ==== pkg/dspm_pkg.sv ====
// Notes on behaviour
// - Lower base window 0x0000-0x7FFF maps straight through, page registers ignored.
// - Effective address bit 15 clear lands in extended page zero, 0x000000-0x007FFF.
// - Upper window with page value zero never reaches extended page zero.
// - Reset loads read-page and write-page selects with 0x001.
// - Upper-window access with selected page zero raises an address error trap.
// - Software write of zero to the read-page or write-page select is ignored.
// - Pages other than zero reachable only through upper window, bit 15 set.
// - Upper-window extended address is page concatenated with effective address bits 14:0.
// - Program addresses are 24 bits, from 23-bit counter or table operations.
// - Ordinary program access confined to lower half of program space.
// - Table read reaches configuration area only when table page bit 7 set.
// - Modulo addressing available in both X and Y spaces.
// - Bit-reversed addressing applies only to X space writes.
// - All data writes use combined X and Y range, no Y split.
// - X/Y boundary fixed per variant, not software programmable.
// - X and Y reads run concurrently on separate paths.
// - X has separate read and write buses; X read carries combined reads.
package dspm_pkg;
	localparam int PAGE_W    = 9;
	localparam int EA_W      = 16;
	localparam int XA_W      = 24;
	localparam int PC_W      = 23;
	localparam int TBL_W     = 8;
	localparam int TBL_CFG_B = 7;

	localparam logic [PAGE_W-1:0] PAGE_RST  = 9'h001;
	localparam logic [PAGE_W-1:0] PAGE_ZERO = 9'h000;
	localparam logic [TBL_W-1:0]  TBL_RST   = 8'h00;
	localparam logic [EA_W-1:0]   Y_BASE    = 16'h4000;

	localparam logic [7:0] OFF_RPAGE  = 8'h00;
	localparam logic [7:0] OFF_WPAGE  = 8'h04;
	localparam logic [7:0] OFF_TPAGE  = 8'h08;
	localparam logic [7:0] OFF_MODCTL = 8'h0c;
	localparam logic [7:0] OFF_XMODS  = 8'h10;
	localparam logic [7:0] OFF_XMODE  = 8'h14;
	localparam logic [7:0] OFF_YMODS  = 8'h18;
	localparam logic [7:0] OFF_YMODE  = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_YBASE  = 8'h24;

	localparam int MC_XMOD = 0;
	localparam int MC_YMOD = 1;
	localparam int MC_BREV = 2;
	localparam int MC_BITS = 4;

	localparam logic [7:0]      MODCTL_RST = 8'h00;
	localparam logic [EA_W-1:0] MOD_RST    = 16'h0000;
	localparam logic [15:0]     CNT_RST    = 16'h0000;
endpackage

// ==== src/dspm_agu.sv ====
`timescale 1ns/10ps
module dspm_agu
	import dspm_pkg::*;
#(
	parameter int AW = EA_W
)(
	// Raw address
	input  wire logic [AW-1:0] ea_in,
	// Modulo window
	input  wire logic          mod_en,
	input  wire logic [AW-1:0] mod_start,
	input  wire logic [AW-1:0] mod_end,
	// Bit reversal
	input  wire logic          brev_en,
	input  wire logic [3:0]    brev_bits,
	// Adjusted address
	output logic      [AW-1:0] ea_out
);
	function automatic logic [AW-1:0] bit_rev(input logic [AW-1:0] a, input logic [3:0] n);
		logic [AW-1:0] r;
		r = a;
		for (int i = 0; i < AW; i++)
		begin
			if (i < int'(n))
				r[i] = a[int'(n) - 1 - i];
		end
		return r;
	endfunction

	// Wrap to the opposite bound so either step direction stays in the buffer
	always_comb
	begin
		ea_out = ea_in;
		if (brev_en)
			ea_out = bit_rev(ea_in, brev_bits);
		else if (mod_en && ea_in > mod_end)
			ea_out = mod_start;
		else if (mod_en && ea_in < mod_start)
			ea_out = mod_end;
	end
endmodule

// ==== src/dspm_mapper.sv ====
`timescale 1ns/10ps
module dspm_mapper
	import dspm_pkg::*;
#(
	parameter logic [EA_W-1:0] Y_START = Y_BASE
)(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// X data request
	input  wire logic              x_req,
	input  wire logic              x_we,
	input  wire logic [EA_W-1:0]   x_ea,
	// Y data request
	input  wire logic              y_req,
	input  wire logic [EA_W-1:0]   y_ea,
	// Program request
	input  wire logic              pc_req,
	input  wire logic [PC_W-1:0]   pc,
	input  wire logic              tbl_req,
	input  wire logic [EA_W-1:0]   tbl_ea,
	// X read bus
	output logic                   xr_valid,
	output logic      [XA_W-1:0]   xr_addr,
	// X write bus
	output logic                   xw_valid,
	output logic      [XA_W-1:0]   xw_addr,
	// Y read bus
	output logic                   yr_valid,
	output logic      [EA_W-1:0]   yr_addr,
	output logic                   y_range_err,
	// Program bus
	output logic                   pg_valid,
	output logic      [XA_W-1:0]   pg_addr,
	output logic                   pg_cfg,
	output logic                   pg_err,
	// Trap
	output logic                   addr_err_trap
);
	logic [PAGE_W-1:0] read_page_select_q;
	logic [PAGE_W-1:0] write_page_select_q;
	logic [TBL_W-1:0]  table_page_select_q;
	logic [7:0]        modctl_q;
	logic [EA_W-1:0]   xmods_q;
	logic [EA_W-1:0]   xmode_q;
	logic [EA_W-1:0]   ymods_q;
	logic [EA_W-1:0]   ymode_q;
	logic [15:0]       trap_cnt_q;
	logic              pready_q;
	logic [31:0]       prdata_q;
	logic              pslverr_q;
	logic              mapped;
	logic [31:0]       rd_mux;
	logic              wr_fire;
	logic [EA_W-1:0]   x_adj;
	logic [EA_W-1:0]   y_adj;
	logic [PAGE_W-1:0] sel_page;
	logic [XA_W-1:0]   x_map;
	logic              x_trap;
	logic [XA_W-1:0]   pg_d;
	logic              pg_cfg_d;
	logic              pg_err_d;

	// APB decode
	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			OFF_RPAGE:  rd_mux = {23'h000000, read_page_select_q};
			OFF_WPAGE:  rd_mux = {23'h000000, write_page_select_q};
			OFF_TPAGE:  rd_mux = {24'h000000, table_page_select_q};
			OFF_MODCTL: rd_mux = {24'h000000, modctl_q};
			OFF_XMODS:  rd_mux = {16'h0000, xmods_q};
			OFF_XMODE:  rd_mux = {16'h0000, xmode_q};
			OFF_YMODS:  rd_mux = {16'h0000, ymods_q};
			OFF_YMODE:  rd_mux = {16'h0000, ymode_q};
			OFF_STATUS: rd_mux = {16'h0000, trap_cnt_q};
			OFF_YBASE:  rd_mux = {16'h0000, Y_START};
			default:    mapped = 1'b0;
		endcase
	end

	// One wait state so read data comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (ce)
		begin
			pready_q  <= psel && penable && !pready_q;
			prdata_q  <= (psel && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr_q <= psel && penable && !pready_q && !mapped;
		end
	end

	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;
	assign wr_fire = ce && psel && penable && pready_q && pwrite;

	// Page selects
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			read_page_select_q  <= PAGE_RST;
			write_page_select_q <= PAGE_RST;
		end
		else if (wr_fire)
		begin
			// Zero would alias page zero through the upper window
			if (paddr == OFF_RPAGE && pwdata[PAGE_W-1:0] != PAGE_ZERO)
				read_page_select_q <= pwdata[PAGE_W-1:0];
			if (paddr == OFF_WPAGE && pwdata[PAGE_W-1:0] != PAGE_ZERO)
				write_page_select_q <= pwdata[PAGE_W-1:0];
		end
	end

	// Table page and addressing modes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			table_page_select_q <= TBL_RST;
			modctl_q            <= MODCTL_RST;
			xmods_q             <= MOD_RST;
			xmode_q             <= MOD_RST;
			ymods_q             <= MOD_RST;
			ymode_q             <= MOD_RST;
		end
		else if (wr_fire)
		begin
			if (paddr == OFF_TPAGE)
				table_page_select_q <= pwdata[TBL_W-1:0];
			if (paddr == OFF_MODCTL)
				modctl_q <= pwdata[7:0];
			if (paddr == OFF_XMODS)
				xmods_q <= pwdata[EA_W-1:0];
			if (paddr == OFF_XMODE)
				xmode_q <= pwdata[EA_W-1:0];
			if (paddr == OFF_YMODS)
				ymods_q <= pwdata[EA_W-1:0];
			if (paddr == OFF_YMODE)
				ymode_q <= pwdata[EA_W-1:0];
		end
	end

	// Address generation, bit reversal offered to X writes only
	dspm_agu #(.AW(EA_W)) u_xagu (
		.ea_in     (x_ea),
		.mod_en    (modctl_q[MC_XMOD]),
		.mod_start (xmods_q),
		.mod_end   (xmode_q),
		.brev_en   (modctl_q[MC_BREV] && x_we),
		.brev_bits (modctl_q[MC_BITS+:4]),
		.ea_out    (x_adj)
	);

	dspm_agu #(.AW(EA_W)) u_yagu (
		.ea_in     (y_ea),
		.mod_en    (modctl_q[MC_YMOD]),
		.mod_start (ymods_q),
		.mod_end   (ymode_q),
		.brev_en   (1'b0),
		.brev_bits (4'h0),
		.ea_out    (y_adj)
	);

	// Data space mapping
	always_comb
	begin
		sel_page = x_we ? write_page_select_q : read_page_select_q;
		x_trap   = 1'b0;
		if (!x_adj[EA_W-1])
			x_map = {{(XA_W-EA_W+1){1'b0}}, x_adj[EA_W-2:0]};
		else
		begin
			x_map  = {sel_page, x_adj[EA_W-2:0]};
			x_trap = (sel_page == PAGE_ZERO);
		end
	end

	// X buses: writes and combined reads, never the Y split
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xr_valid <= 1'b0;
			xw_valid <= 1'b0;
			xr_addr  <= '0;
			xw_addr  <= '0;
		end
		else if (ce)
		begin
			xr_valid <= x_req && !x_we && !x_trap;
			xw_valid <= x_req && x_we && !x_trap;
			if (x_req && !x_we)
				xr_addr <= x_map;
			if (x_req && x_we)
				xw_addr <= x_map;
		end
	end

	// Y read path runs alongside X for dual-operand fetches
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			yr_valid    <= 1'b0;
			yr_addr     <= '0;
			y_range_err <= 1'b0;
		end
		else if (ce)
		begin
			yr_valid    <= y_req && (y_adj >= Y_START);
			y_range_err <= y_req && (y_adj < Y_START);
			if (y_req)
				yr_addr <= y_adj;
		end
	end

	// Trap and its count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_err_trap <= 1'b0;
			trap_cnt_q    <= CNT_RST;
		end
		else if (ce)
		begin
			addr_err_trap <= x_req && x_trap;
			if (x_req && x_trap)
				trap_cnt_q <= trap_cnt_q + 16'h0001;
		end
	end

	// Program space: fetch has priority over table reads
	always_comb
	begin
		pg_cfg_d = 1'b0;
		pg_err_d = 1'b0;
		if (pc_req)
		begin
			pg_d     = {1'b0, pc};
			pg_err_d = pg_d[XA_W-1];
		end
		else
		begin
			pg_d = {table_page_select_q, tbl_ea};
			if (pg_d[XA_W-1])
			begin
				pg_cfg_d = tbl_req && table_page_select_q[TBL_CFG_B];
				pg_err_d = !pg_cfg_d;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pg_valid <= 1'b0;
			pg_addr  <= '0;
			pg_cfg   <= 1'b0;
			pg_err   <= 1'b0;
		end
		else if (ce)
		begin
			pg_valid <= (pc_req || tbl_req) && !pg_err_d;
			pg_cfg   <= (pc_req || tbl_req) && pg_cfg_d;
			pg_err   <= (pc_req || tbl_req) && pg_err_d;
			if (pc_req || tbl_req)
				pg_addr <= pg_d;
		end
	end

	property p_lower_direct;
		@(posedge pclk) disable iff (!presetn)
		(ce && x_req && !x_we && !x_adj[15]) |=> (xr_addr == {9'h000, $past(x_adj[14:0])});
	endproperty
	a_lower_direct: assert property (p_lower_direct) else $error("lower window not direct");

	property p_page_zero_range;
		@(posedge pclk) disable iff (!presetn)
		(ce && x_req && x_we && !x_ea[15] && !modctl_q[MC_BREV] && !modctl_q[MC_XMOD])
			|=> (xw_addr <= 24'h007fff);
	endproperty
	a_page_zero_range: assert property (p_page_zero_range) else $error("page zero range wrong");

	property p_no_zero_page;
		@(posedge pclk) disable iff (!presetn)
		(read_page_select_q != 9'h000) && (write_page_select_q != 9'h000);
	endproperty
	a_no_zero_page: assert property (p_no_zero_page) else $error("page select reached zero");

	property p_reset_pages;
		@(posedge pclk)
		$rose(presetn) |-> (read_page_select_q == 9'h001) && (write_page_select_q == 9'h001);
	endproperty
	a_reset_pages: assert property (p_reset_pages) else $error("page reset value wrong");

	property p_zero_write_ignored;
		@(posedge pclk) disable iff (!presetn)
		(wr_fire && paddr == OFF_RPAGE && pwdata[8:0] == 9'h000)
			|=> $stable(read_page_select_q);
	endproperty
	a_zero_write_ignored: assert property (p_zero_write_ignored) else $error("zero page write took");

	property p_upper_map;
		@(posedge pclk) disable iff (!presetn)
		(ce && x_req && !x_we && x_ea[15] && !modctl_q[MC_XMOD])
			|=> (xr_addr == {$past(read_page_select_q), $past(x_ea[14:0])});
	endproperty
	a_upper_map: assert property (p_upper_map) else $error("upper window mapping wrong");

	property p_write_page_used;
		@(posedge pclk) disable iff (!presetn)
		(ce && x_req && x_we && x_ea[15] && !modctl_q[MC_XMOD] && !modctl_q[MC_BREV])
			|=> xw_valid && (xw_addr[23:15] == $past(write_page_select_q));
	endproperty
	a_write_page_used: assert property (p_write_page_used) else $error("write page not applied");

	property p_pc_map;
		@(posedge pclk) disable iff (!presetn)
		(ce && pc_req) |=> (pg_addr == {1'b0, $past(pc)}) && !pg_cfg;
	endproperty
	a_pc_map: assert property (p_pc_map) else $error("program address wrong");

	property p_cfg_needs_bit7;
		@(posedge pclk) disable iff (!presetn)
		pg_cfg |-> $past(table_page_select_q[7]) && $past(tbl_req) && !$past(pc_req);
	endproperty
	a_cfg_needs_bit7: assert property (p_cfg_needs_bit7) else $error("config area reached wrongly");

	property p_y_no_brev;
		@(posedge pclk) disable iff (!presetn)
		(ce && y_req && !modctl_q[MC_YMOD] && y_ea >= Y_START) |=> yr_valid && (yr_addr == $past(y_ea));
	endproperty
	a_y_no_brev: assert property (p_y_no_brev) else $error("Y address altered");

	property p_dual_fetch;
		@(posedge pclk) disable iff (!presetn)
		(ce && x_req && !x_we && y_req && y_ea >= Y_START && !modctl_q[MC_YMOD] && !(x_ea[15]))
			|=> xr_valid && yr_valid;
	endproperty
	a_dual_fetch: assert property (p_dual_fetch) else $error("dual fetch not concurrent");
endmodule

// ==== tb/dspm_core_model.sv ====
`timescale 1ns/10ps
module dspm_core_model
	import dspm_pkg::*;
(
	// Clock
	input  wire logic            pclk,
	// Core requests
	output logic                 x_req,
	output logic                 x_we,
	output logic [EA_W-1:0]      x_ea,
	output logic                 y_req,
	output logic [EA_W-1:0]      y_ea,
	output logic                 pc_req,
	output logic [PC_W-1:0]      pc,
	output logic                 tbl_req,
	output logic [EA_W-1:0]      tbl_ea
);
	initial
	begin
		{x_req, x_we, y_req, pc_req, tbl_req} = 5'h00;
		{x_ea, y_ea, tbl_ea} = 48'h0;
		pc = 23'h0;
	end

	// Kind 0 X, 1 Y, 2 fetch, 3 table; one request cycle
	task automatic issue(input logic [1:0] kind, input logic we, input logic [PC_W-1:0] a);
	begin
		@(posedge pclk);
		x_req <= (kind == 2'd0);
		y_req <= (kind == 2'd1);
		pc_req <= (kind == 2'd2);
		tbl_req <= (kind == 2'd3);
		x_we <= we;
		{x_ea, y_ea, tbl_ea} <= {3{a[EA_W-1:0]}};
		pc <= a;
		@(posedge pclk);
		{x_req, y_req, pc_req, tbl_req} <= 4'h0;
		// Released lines flip so a stale address never passes
		{x_ea, y_ea, tbl_ea} <= ~{3{a[EA_W-1:0]}};
		pc <= ~a;
	end
	endtask

	// X read and Y read in one cycle, as a dual-operand fetch
	task automatic issue_dual(input logic [EA_W-1:0] xa, input logic [EA_W-1:0] ya);
	begin
		@(posedge pclk);
		x_req <= 1'b1;
		y_req <= 1'b1;
		x_we <= 1'b0;
		x_ea <= xa;
		y_ea <= ya;
		@(posedge pclk);
		x_req <= 1'b0;
		y_req <= 1'b0;
		x_ea <= ~xa;
		y_ea <= ~ya;
	end
	endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench
	import dspm_pkg::*;
;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              x_req;
	logic              x_we;
	logic [EA_W-1:0]   x_ea;
	logic              y_req;
	logic [EA_W-1:0]   y_ea;
	logic              pc_req;
	logic [PC_W-1:0]   pc;
	logic              tbl_req;
	logic [EA_W-1:0]   tbl_ea;
	logic              xr_valid;
	logic [XA_W-1:0]   xr_addr;
	logic              xw_valid;
	logic [XA_W-1:0]   xw_addr;
	logic              yr_valid;
	logic [EA_W-1:0]   yr_addr;
	logic              y_range_err;
	logic              pg_valid;
	logic [XA_W-1:0]   pg_addr;
	logic              pg_cfg;
	logic              pg_err;
	logic              addr_err_trap;
	logic [31:0]       rdat;
	logic              rerr;
	int                fails;
	int                cmp_count;
	int                cyc;

	dspm_mapper i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .x_req(x_req), .x_we(x_we), .x_ea(x_ea), .y_req(y_req), .y_ea(y_ea),
		.pc_req(pc_req), .pc(pc), .tbl_req(tbl_req), .tbl_ea(tbl_ea), .xr_valid(xr_valid),
		.xr_addr(xr_addr), .xw_valid(xw_valid), .xw_addr(xw_addr), .yr_valid(yr_valid),
		.yr_addr(yr_addr), .y_range_err(y_range_err), .pg_valid(pg_valid), .pg_addr(pg_addr),
		.pg_cfg(pg_cfg), .pg_err(pg_err), .addr_err_trap(addr_err_trap));

	dspm_core_model i_core (.pclk(pclk), .x_req(x_req), .x_we(x_we), .x_ea(x_ea), .y_req(y_req),
		.y_ea(y_ea), .pc_req(pc_req), .pc(pc), .tbl_req(tbl_req), .tbl_ea(tbl_ea));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	end
	endtask

	// Holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	// Core access, outputs judged one cycle after the request
	task automatic xs(input logic [1:0] k, input logic we, input logic [PC_W-1:0] a);
	begin
		i_core.issue(k, we, a);
		#1;
	end
	endtask

	task automatic t_regs;
	begin
		apb(1'b0, OFF_RPAGE, 32'h0);
		chk("read page reset", 32'h0000_0001, rdat);
		apb(1'b0, OFF_WPAGE, 32'h0);
		chk("write page reset", 32'h0000_0001, rdat);
		apb(1'b0, OFF_YBASE, 32'h0);
		chk("y boundary", 32'h0000_4000, rdat);
		apb(1'b1, OFF_YBASE, 32'h0000_1000);
		apb(1'b0, OFF_YBASE, 32'h0);
		chk("y boundary fixed", 32'h0000_4000, rdat);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		$display("test regs done");
	end
	endtask

	task automatic t_window;
	begin
		xs(2'd0, 1'b0, 23'h001234);
		chk("lower read", 32'h0100_1234, {7'h0, xr_valid, xr_addr});
		apb(1'b1, OFF_WPAGE, 32'h0000_0002);
		xs(2'd0, 1'b1, 23'h007fff);
		chk("lower write", 32'h0100_7fff, {7'h0, xw_valid, xw_addr});
		xs(2'd0, 1'b1, 23'h008010);
		chk("upper write p2", 32'h0101_0010, {7'h0, xw_valid, xw_addr});
		xs(2'd0, 1'b0, 23'h00ffff);
		chk("upper read p1", 32'h0100_ffff, {7'h0, xr_valid, xr_addr});
		$display("test window done");
	end
	endtask

	task automatic t_zero;
	begin
		apb(1'b1, OFF_RPAGE, 32'h0000_0000);
		apb(1'b0, OFF_RPAGE, 32'h0);
		chk("zero write ignored", 32'h0000_0001, rdat);
		xs(2'd0, 1'b0, 23'h008000);
		chk("no page zero", 32'h0100_8000, {7'h0, xr_valid, xr_addr});
		chk("no trap", 32'h0, {31'h0, addr_err_trap});
		$display("test zero done");
	end
	endtask

	task automatic t_prog;
	begin
		xs(2'd2, 1'b0, 23'h7fffff);
		chk("fetch", 32'h017f_ffff, {7'h0, pg_valid, pg_addr});
		chk("fetch err", 32'h0, {31'h0, pg_err});
		apb(1'b1, OFF_TPAGE, 32'h0000_0080);
		xs(2'd3, 1'b0, 23'h000002);
		chk("table cfg", 32'h0380_0002, {6'h0, pg_valid, pg_cfg, pg_addr});
		apb(1'b1, OFF_TPAGE, 32'h0000_007f);
		xs(2'd3, 1'b0, 23'h00fffe);
		chk("table low", 32'h027f_fffe, {6'h0, pg_valid, pg_cfg, pg_addr});
		$display("test prog done");
	end
	endtask

	task automatic t_ymod;
	begin
		xs(2'd1, 1'b0, 23'h005000);
		chk("y read", 32'h0002_5000, {14'h0, yr_valid, y_range_err, yr_addr});
		xs(2'd1, 1'b0, 23'h001000);
		chk("y below", 32'h1, {31'h0, y_range_err});
		i_core.issue_dual(16'h0200, 16'h4800);
		#1;
		chk("dual fetch", 32'h0003_4800, {14'h0, xr_valid, yr_valid, yr_addr});
		chk("dual x addr", 32'h0000_0200, {8'h0, xr_addr});
		apb(1'b1, OFF_XMODS, 32'h0000_1000);
		apb(1'b1, OFF_XMODE, 32'h0000_10ff);
		apb(1'b1, OFF_MODCTL, 32'h0000_0001);
		xs(2'd0, 1'b0, 23'h001100);
		chk("x modulo wrap", 32'h0100_1000, {7'h0, xr_valid, xr_addr});
		$display("test ymod done");
	end
	endtask

	task automatic give_verdict;
	begin
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			give_verdict();
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fails = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_window();
		t_zero();
		t_prog();
		t_ymod();
		give_verdict();
	end
endmodule
